// ### rtl/kci_pkg.sv
// constants, codes and state types of the keyboard command interpreter
// Contract
// - hold power-up reset 150 ms to 2 s
// - self-test ignores link, indicators on then off
// - self-test lasts 300 to 500 ms
// - pass sends AA and scans; fail disables
// - completion byte timing after reset
// - decode the host command byte set
// - reply within 20 ms unless testing
// - default-disable: ack, flush, defaults, stop scanning
// - echo returns EE, scanning unchanged
// - enable: ack, flush, clear typematic, scan
// - EF or F1 get resend, nothing else
// - identify: ack, two id bytes, resume
// - resend repeats last non-resend output byte
// - reset waits for lines idle 500 us
// - after reset: self-test, completion, scan set 2
// - scan-set select: ack, flush, ack option 1-3
// - option 00 reports set; restore scanning
// - set-all-keys: ack, flush, store type
// - set-default: ack, flush, defaults, keep scanning
// - set-key-type: ack, flush, then key identifiers
// - indicators: ack, pause, await option byte
// - option bit set lights indicator; ack, resume
// - command instead of option abandons indicator update
// - ack FA, resend FE, failure FC
package kci_pkg;
  localparam int unsigned CLK_KHZ = 50000;
  localparam int unsigned POR_MIN_MS = 150;
  localparam int unsigned BAT_MIN_MS = 300;
  localparam int unsigned IDLE_MIN_US = 500;
  localparam int unsigned POR_CYC = POR_MIN_MS * CLK_KHZ;
  localparam int unsigned BAT_CYC = BAT_MIN_MS * CLK_KHZ;
  localparam int unsigned IDLE_CYC = (IDLE_MIN_US * CLK_KHZ + 999) / 1000;
  localparam logic [7:0] RSP_ACK = 8'hfa;
  localparam logic [7:0] RSP_RESEND = 8'hfe;
  localparam logic [7:0] RSP_FAIL = 8'hfc;
  localparam logic [7:0] RSP_PASS = 8'haa;
  localparam logic [7:0] CMD_LED = 8'hed;
  localparam logic [7:0] CMD_ECHO = 8'hee;
  localparam logic [7:0] CMD_SCANSET = 8'hf0;
  localparam logic [7:0] CMD_IDENT = 8'hf2;
  localparam logic [7:0] CMD_RATE = 8'hf3;
  localparam logic [7:0] CMD_ENABLE = 8'hf4;
  localparam logic [7:0] CMD_DFLT_DIS = 8'hf5;
  localparam logic [7:0] CMD_DEFAULT = 8'hf6;
  localparam logic [7:0] CMD_ALLK_LO = 8'hf7;
  localparam logic [7:0] CMD_ALLK_HI = 8'hfa;
  localparam logic [7:0] CMD_KEYT_LO = 8'hfb;
  localparam logic [7:0] CMD_KEYT_HI = 8'hfd;
  localparam logic [7:0] CMD_RESEND = 8'hfe;
  localparam logic [7:0] CMD_RESET = 8'hff;
  localparam logic [7:0] SET_OPT_LIM = 8'h04;
  localparam logic [1:0] SET_DEFAULT = 2'h2;
  localparam logic [2:0] LED_ALL = 3'h7;
  localparam logic [2:0] LED_OFF = 3'h0;
  localparam int CNT_W = 25;

  typedef enum logic [5:0] {
    ST_POR = 6'h01,
    ST_BAT = 6'h02,
    ST_IDLE = 6'h04,
    ST_TX = 6'h08,
    ST_OPT = 6'h10,
    ST_RSTW = 6'h20
  } kci_st_e;

  typedef enum logic [1:0] {
    OPT_LED = 2'h0,
    OPT_SET = 2'h1,
    OPT_RATE = 2'h2,
    OPT_KEY = 2'h3
  } kci_opt_e;

  // one-cycle effects toward scanner, buffer and typematic logic
  typedef struct packed {
    logic flush;
    logic clr_tm;
    logic dflt;
    logic all_wr;
    logic key_wr;
    logic rate_wr;
    logic [1:0] ktype;
    logic [7:0] val;
  } kci_evt_s;

  typedef struct packed {
    kci_st_e st;
    kci_st_e ret;
    kci_opt_e opt;
    logic [CNT_W-1:0] cnt;
    logic rx_s1;
    logic rx_s2;
    logic rx_s3;
    logic idl_s1;
    logic idl_s2;
    logic ack_s1;
    logic ack_s2;
    logic rx_pend;
    logic [7:0] rx_byte;
    logic tx_req;
    logic tx_busy;
    logic [7:0] tx_data;
    logic [1:0] tx_cnt;
    logic [2:0][7:0] tx_buf;
    logic [7:0] last;
    logic scan;
    logic scan_prev;
    logic resume;
    logic [2:0] leds;
    logic [1:0] set;
    logic [1:0] ktype;
    logic bat_run;
    kci_evt_s evt;
  } kci_sys_s;

  typedef struct packed {
    logic rst_s1;
    logic rst_s2;
    logic req_s1;
    logic req_s2;
    logic rx_tgl;
    logic [7:0] rx_hold;
    logic tx_vld;
    logic [7:0] tx_byte;
    logic ack_tgl;
  } kci_lnk_s;
endpackage : kci_pkg

// ### rtl/kci_cmd_interp.sv
// keyboard power-up sequencer and host command interpreter
`timescale 1ns/100ps
`default_nettype none
module kci_cmd_interp
  import kci_pkg::*;
#(
  parameter int unsigned POR_CYCLES = POR_CYC,
  parameter int unsigned BAT_CYCLES = BAT_CYC,
  parameter int unsigned IDLE_CYCLES = IDLE_CYC,
  // identification bytes, values arbitrary
  parameter logic [7:0] ID_LO = 8'h5a,
  parameter logic [7:0] ID_HI = 8'h1c
) (
  // system clock and power-on reset
  input wire logic sys_clk_i,
  input wire logic srst_i,
  // link byte side, on the link clock
  input wire logic link_clk_i,
  input wire logic rx_strobe_i,
  input wire logic [7:0] rx_byte_i,
  input wire logic tx_done_i,
  output logic tx_valid_o,
  output logic [7:0] tx_byte_o,
  // link pins both high, asynchronous
  input wire logic line_idle_i,
  // self-test checker
  input wire logic self_test_fail_i,
  output logic self_test_run_o,
  // keyboard settings and effects
  output logic scan_en_o,
  output logic [1:0] scan_set_o,
  output logic [2:0] leds_o,
  output kci_evt_s evt_o
);
  kci_sys_s q;
  kci_sys_s d;
  kci_lnk_s l_q;
  kci_lnk_s ld;
  logic rx_evt;
  logic take;
  logic cmd_go;
  logic opt_ok;
  logic [7:0] b;

  // system domain
  always_comb begin
    d = q;
    d.evt = '0;
    d.rx_s1 = l_q.rx_tgl;
    d.rx_s2 = q.rx_s1;
    d.rx_s3 = q.rx_s2;
    d.idl_s1 = line_idle_i;
    d.idl_s2 = q.idl_s1;
    d.ack_s1 = l_q.ack_tgl;
    d.ack_s2 = q.ack_s1;
    rx_evt = q.rx_s2 ^ q.rx_s3;
    take = q.rx_pend && (q.st inside {ST_IDLE, ST_OPT, ST_RSTW});
    b = q.rx_byte;
    cmd_go = 1'b0;
    case (q.opt)
      OPT_LED: opt_ok = (b[7:3] == 5'h00);
      OPT_SET: opt_ok = (b < SET_OPT_LIM);
      OPT_RATE: opt_ok = !b[7];
      OPT_KEY: opt_ok = (b < CMD_LED);
      default: opt_ok = 1'b0;
    endcase
    if (rx_evt) begin
      d.rx_byte = l_q.rx_hold;
    end
    // a new byte wins over the take of the old one
    d.rx_pend = (q.rx_pend && !take) || rx_evt;
    if (q.tx_busy && (q.ack_s2 == q.tx_req)) begin
      d.tx_busy = 1'b0;
    end
    case (q.st)
      ST_POR: begin
        d.cnt = q.cnt + 1'b1;
        if (q.cnt == CNT_W'(POR_CYCLES - 1)) begin
          d.st = ST_BAT;
          d.cnt = '0;
          d.leds = LED_ALL;
          d.bat_run = 1'b1;
        end
      end
      ST_BAT: begin
        d.rx_pend = 1'b0;
        d.cnt = q.cnt + 1'b1;
        if (q.cnt == CNT_W'(BAT_CYCLES - 1)) begin
          d.leds = LED_OFF;
          d.bat_run = 1'b0;
          d.set = SET_DEFAULT;
          d.scan = !self_test_fail_i;
          d.tx_buf[0] = self_test_fail_i ? RSP_FAIL : RSP_PASS;
          d.tx_cnt = 2'd1;
          d.ret = ST_IDLE;
          d.resume = 1'b0;
          d.st = ST_TX;
        end
      end
      ST_TX: begin
        if (!q.tx_busy) begin
          if (q.tx_cnt != 2'd0) begin
            d.tx_data = q.tx_buf[0];
            d.tx_req = ~q.tx_req;
            d.tx_busy = 1'b1;
            d.tx_buf[0] = q.tx_buf[1];
            d.tx_buf[1] = q.tx_buf[2];
            d.tx_cnt = q.tx_cnt - 2'd1;
            if (q.tx_buf[0] != RSP_RESEND) begin
              d.last = q.tx_buf[0];
            end
          end else begin
            d.st = q.ret;
            if (q.resume) begin
              d.scan = q.scan_prev;
            end
            d.resume = 1'b0;
          end
        end
      end
      ST_RSTW: begin
        d.cnt = q.idl_s2 ? q.cnt + 1'b1 : '0;
        if (q.idl_s2 && q.cnt == CNT_W'(IDLE_CYCLES - 1) && !take) begin
          d.st = ST_BAT;
          d.cnt = '0;
          d.leds = LED_ALL;
          d.bat_run = 1'b1;
          d.rx_pend = 1'b0;
        end
      end
      ST_IDLE: begin
        d.cnt = '0;
      end
      ST_OPT: begin
        d.cnt = '0;
      end
      default: begin
        d.st = ST_POR;
      end
    endcase
    if (take) begin
      d.tx_cnt = 2'd1;
      d.tx_buf[0] = RSP_ACK;
      d.st = ST_TX;
      d.ret = ST_IDLE;
      d.resume = 1'b0;
      if (q.st == ST_OPT && opt_ok) begin
        case (q.opt)
          OPT_LED: begin
            d.leds = b[2:0];
            d.scan = q.scan_prev;
          end
          OPT_SET: begin
            d.scan = q.scan_prev;
            if (b == 8'h00) begin
              d.tx_buf[1] = {6'h00, q.set};
              d.tx_cnt = 2'd2;
            end else begin
              d.set = b[1:0];
            end
          end
          OPT_RATE: begin
            d.evt.rate_wr = 1'b1;
            d.evt.val = b;
            d.scan = q.scan_prev;
          end
          default: begin
            d.evt.key_wr = 1'b1;
            d.evt.ktype = q.ktype;
            d.evt.val = b;
            d.ret = ST_OPT;
          end
        endcase
      end else begin
        if (q.st == ST_OPT && q.opt != OPT_KEY) begin
          d.scan = q.scan_prev;
        end
        cmd_go = 1'b1;
      end
    end
    if (cmd_go) begin
      case (b) inside
        CMD_DFLT_DIS: begin
          d.evt.flush = 1'b1;
          d.evt.dflt = 1'b1;
          d.evt.clr_tm = 1'b1;
          d.scan = 1'b0;
        end
        CMD_ECHO: begin
          d.tx_buf[0] = CMD_ECHO;
        end
        CMD_ENABLE: begin
          d.evt.flush = 1'b1;
          d.evt.clr_tm = 1'b1;
          d.scan = 1'b1;
        end
        CMD_IDENT: begin
          d.tx_buf[1] = ID_LO;
          d.tx_buf[2] = ID_HI;
          d.tx_cnt = 2'd3;
          d.scan_prev = d.scan;
          d.scan = 1'b0;
          d.resume = 1'b1;
        end
        CMD_RESEND: begin
          d.tx_buf[0] = q.last;
        end
        CMD_RESET: begin
          d.scan = 1'b0;
          d.ret = ST_RSTW;
          d.cnt = '0;
        end
        CMD_SCANSET: begin
          d.evt.flush = 1'b1;
          d.evt.clr_tm = 1'b1;
          d.scan_prev = d.scan;
          d.scan = 1'b0;
          d.ret = ST_OPT;
          d.opt = OPT_SET;
        end
        [CMD_ALLK_LO:CMD_ALLK_HI]: begin
          d.evt.flush = 1'b1;
          d.evt.all_wr = 1'b1;
          d.evt.ktype = 2'(b - CMD_ALLK_LO);
        end
        CMD_DEFAULT: begin
          d.evt.flush = 1'b1;
          d.evt.dflt = 1'b1;
          d.evt.clr_tm = 1'b1;
        end
        [CMD_KEYT_LO:CMD_KEYT_HI]: begin
          d.evt.flush = 1'b1;
          d.ktype = 2'(b - CMD_KEYT_LO);
          d.ret = ST_OPT;
          d.opt = OPT_KEY;
        end
        CMD_LED: begin
          d.scan_prev = d.scan;
          d.scan = 1'b0;
          d.ret = ST_OPT;
          d.opt = OPT_LED;
        end
        CMD_RATE: begin
          d.scan_prev = d.scan;
          d.scan = 1'b0;
          d.ret = ST_OPT;
          d.opt = OPT_RATE;
        end
        default: begin
          d.tx_buf[0] = RSP_RESEND;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      q <= '0;
      q.st <= ST_POR;
      q.ret <= ST_IDLE;
      q.opt <= OPT_LED;
      q.set <= SET_DEFAULT;
      q.leds <= LED_OFF;
    end else begin
      q <= d;
    end
  end

  // link domain; reset arrives through two flops
  always_comb begin
    ld = l_q;
    ld.rst_s1 = srst_i;
    ld.rst_s2 = l_q.rst_s1;
    ld.req_s1 = q.tx_req;
    ld.req_s2 = l_q.req_s1;
    if (rx_strobe_i) begin
      ld.rx_hold = rx_byte_i;
      ld.rx_tgl = ~l_q.rx_tgl;
    end
    if (l_q.tx_vld && tx_done_i) begin
      ld.tx_vld = 1'b0;
      ld.ack_tgl = ~l_q.ack_tgl;
    end else if (!l_q.tx_vld && (l_q.req_s2 != l_q.ack_tgl)) begin
      // data word held stable by the request toggle
      ld.tx_vld = 1'b1;
      ld.tx_byte = q.tx_data;
    end
  end

  always_ff @(posedge link_clk_i) begin
    l_q <= ld;
    if (l_q.rst_s2) begin
      l_q.rx_tgl <= 1'b0;
      l_q.tx_vld <= 1'b0;
      l_q.ack_tgl <= 1'b0;
      l_q.req_s1 <= 1'b0;
      l_q.req_s2 <= 1'b0;
    end
  end

  assign tx_valid_o = l_q.tx_vld;
  assign tx_byte_o = l_q.tx_byte;
  assign self_test_run_o = q.bat_run;
  assign scan_en_o = q.scan;
  assign scan_set_o = q.set;
  assign leds_o = q.leds;
  assign evt_o = q.evt;

  // checks on the system domain
  localparam int REPLY_MAX = 3;
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (srst_i);

  property p_por_len;
    (q.st == ST_POR) ##1 (q.st == ST_BAT) |-> $past(q.cnt) == CNT_W'(POR_CYCLES - 1);
  endproperty
  a_por_len: assert property (p_por_len) else $error("power-up hold wrong length");

  property p_bat_ign;
    (q.st == ST_BAT) ##1 (q.st == ST_BAT) |-> !q.rx_pend && q.leds == LED_ALL && q.bat_run;
  endproperty
  a_bat_ign: assert property (p_bat_ign) else $error("self-test not isolated");

  property p_bat_len;
    (q.st == ST_BAT) ##1 (q.st == ST_TX) |-> $past(q.cnt) == CNT_W'(BAT_CYCLES - 1)
      && q.leds == LED_OFF && q.set == SET_DEFAULT;
  endproperty
  a_bat_len: assert property (p_bat_len) else $error("self-test end wrong");

  property p_bat_res;
    (q.st == ST_BAT) ##1 (q.st == ST_TX) |->
      q.tx_buf[0] == ($past(self_test_fail_i) ? RSP_FAIL : RSP_PASS)
      && q.scan == !$past(self_test_fail_i);
  endproperty
  a_bat_res: assert property (p_bat_res) else $error("self-test result wrong");

  property p_reply;
    take |-> ##[1:REPLY_MAX] $changed(q.tx_req);
  endproperty
  a_reply: assert property (p_reply) else $error("no prompt reply");

  property p_echo;
    take && q.st == ST_IDLE && b == CMD_ECHO |=>
      q.tx_buf[0] == CMD_ECHO && q.scan == $past(q.scan);
  endproperty
  a_echo: assert property (p_echo) else $error("echo wrong");

  property p_enable;
    take && q.st == ST_IDLE && b == CMD_ENABLE |=>
      q.tx_buf[0] == RSP_ACK && q.scan && q.evt.flush && q.evt.clr_tm;
  endproperty
  a_enable: assert property (p_enable) else $error("enable wrong");

  property p_invalid;
    take && q.st == ST_IDLE && (b == 8'hef || b == 8'hf1) |=>
      q.tx_buf[0] == RSP_RESEND && q.scan == $past(q.scan) && q.evt == '0;
  endproperty
  a_invalid: assert property (p_invalid) else $error("invalid command answered");

  property p_resend;
    take && q.st == ST_IDLE && b == CMD_RESEND |=> q.tx_buf[0] == $past(q.last);
  endproperty
  a_resend: assert property (p_resend) else $error("resend byte wrong");

  property p_reset;
    take && b == CMD_RESET |=> !q.scan && q.ret == ST_RSTW && q.st == ST_TX;
  endproperty
  a_reset: assert property (p_reset) else $error("reset not held");

  property p_led_abandon;
    take && q.st == ST_OPT && q.opt == OPT_LED && !opt_ok |=> q.leds == $past(q.leds);
  endproperty
  a_led_abandon: assert property (p_led_abandon) else $error("indicators changed");

  c_echo: cover property (take && b == CMD_ECHO);
  c_ident: cover property (q.st == ST_TX && q.tx_cnt == 2'd3);
  c_led: cover property (take && q.st == ST_OPT && q.opt == OPT_LED && opt_ok);
  c_rst_bat: cover property ((q.st == ST_RSTW) ##1 (q.st == ST_BAT));
endmodule : kci_cmd_interp
`default_nettype wire

// ### verification/kci_host_model.sv
// host-side byte partner: sends command bytes, takes keyboard replies
`timescale 1ns/100ps
`default_nettype none
module kci_host_model (
  // link clock and stall length
  input wire logic link_clk_i,
  input wire logic [1:0] stall_i,
  // reply side
  input wire logic tx_valid_i,
  input wire logic [7:0] tx_byte_i,
  output logic tx_done_o,
  // command side
  output logic rx_strobe_o,
  output logic [7:0] rx_byte_o
);
  logic [7:0] got[$];
  int wait_n = 0;
  initial begin
    tx_done_o = 1'b0;
    rx_strobe_o = 1'b0;
    rx_byte_o = 8'h00;
  end
  // takes a waiting reply after a stall of up to three link cycles
  always @(posedge link_clk_i) begin
    if (tx_done_o) begin
      tx_done_o <= 1'b0;
    end else if (tx_valid_i === 1'b1 && wait_n < stall_i) begin
      wait_n <= wait_n + 1;
    end else if (tx_valid_i === 1'b1) begin
      wait_n <= 0;
      got.push_back(tx_byte_i);
      tx_done_o <= 1'b1;
    end
  end
  // one byte in one link cycle; data scrambled once it is no longer valid
  task send(input logic [7:0] b);
    @(posedge link_clk_i);
    rx_strobe_o <= 1'b1;
    rx_byte_o <= b;
    @(posedge link_clk_i);
    rx_strobe_o <= 1'b0;
    rx_byte_o <= ~b;
  endtask : send
endmodule : kci_host_model
`default_nettype wire

// ### verification/kci_cmd_interp_bench.sv
// self-checking bench of the keyboard command interpreter
`timescale 1ns/100ps
`default_nettype none
module kci_cmd_interp_bench
  import kci_pkg::*;
;
  localparam int POR_C = 20;
  localparam int BAT_C = 30;
  localparam int IDLE_C = 10;
  // identification bytes, values arbitrary
  localparam logic [7:0] ID_A = 8'h5a;
  localparam logic [7:0] ID_B = 8'h1c;
  logic sys_clk_i = 1'b0;
  logic link_clk = 1'b0;
  logic srst_i = 1'b1;
  logic line_idle = 1'b0;
  logic st_fail = 1'b0;
  logic [1:0] stall = 2'h0;
  logic rx_stb, tx_done, tx_valid, st_run, scan_en;
  logic [7:0] rx_byte, tx_byte;
  logic [1:0] scan_set;
  logic [2:0] leds;
  kci_evt_s evt;
  int n_errors = 0, n_tests = 0, n_flush = 0, m_flush = 0, run_len = 0;
  int m_scan = 0, m_set = 2, m_leds = 0, m_last = 0, m_opt = 0, m_prev = 0;
  logic [7:0] exp_q[$];
  logic [15:0] xev_q[$];
  logic [15:0] ev_q[$];
  logic [1:0] m_kt = 2'h0;

  always #10 sys_clk_i = ~sys_clk_i;
  initial #7 forever #32 link_clk = ~link_clk;
  always @(posedge sys_clk_i) if (evt.flush === 1'b1) n_flush++;
  always @(posedge sys_clk_i) if (st_run === 1'b1) run_len++;
  always @(posedge sys_clk_i) if ({evt} != 16'h0000) ev_q.push_back({evt});

  kci_cmd_interp #(
    .POR_CYCLES(POR_C),
    .BAT_CYCLES(BAT_C),
    .IDLE_CYCLES(IDLE_C),
    .ID_LO(ID_A),
    .ID_HI(ID_B)
  ) dut_u (
    .sys_clk_i(sys_clk_i), .srst_i(srst_i), .link_clk_i(link_clk),
    .rx_strobe_i(rx_stb), .rx_byte_i(rx_byte), .tx_done_i(tx_done),
    .tx_valid_o(tx_valid), .tx_byte_o(tx_byte), .line_idle_i(line_idle),
    .self_test_fail_i(st_fail), .self_test_run_o(st_run), .scan_en_o(scan_en),
    .scan_set_o(scan_set), .leds_o(leds), .evt_o(evt)
  );

  kci_host_model host_u (
    .link_clk_i(link_clk), .stall_i(stall), .tx_valid_i(tx_valid), .tx_byte_i(tx_byte),
    .tx_done_o(tx_done), .rx_strobe_o(rx_stb), .rx_byte_o(rx_byte)
  );

  task chk(input string what, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  task put(input logic [7:0] x);
    exp_q.push_back(x);
    if (x != RSP_RESEND) m_last = x;
  endtask : put

  // expected event pulse: flags flush, clr_tm, dflt, all_wr, key_wr, rate_wr
  task ev(input logic [5:0] f, input logic [1:0] t, input logic [7:0] v);
    xev_q.push_back({f, t, v});
  endtask : ev

  // reference model: expected replies and settings per host byte
  task mdl(input logic [7:0] b);
    int o;
    o = m_opt;
    m_opt = 0;
    if (o == 1 || o == 2 || o == 4) m_scan = m_prev;
    if (o == 1 && b[7:3] == 5'h00) begin
      put(RSP_ACK);
      m_leds = b[2:0];
    end else if (o == 2 && b < 8'h04) begin
      put(RSP_ACK);
      if (b == 8'h00) put(8'(m_set));
      else m_set = b;
    end else if (o == 3 && b < CMD_LED) begin
      put(RSP_ACK);
      ev(6'h02, m_kt, b);
      m_opt = 3;
    end else if (o == 4 && !b[7]) begin
      put(RSP_ACK);
      ev(6'h01, 2'h0, b);
    end else begin
      case (b)
        CMD_ECHO: put(CMD_ECHO);
        CMD_ENABLE, CMD_DFLT_DIS: begin
          put(RSP_ACK);
          m_scan = (b == CMD_ENABLE);
          m_flush++;
          ev((b == CMD_ENABLE) ? 6'h30 : 6'h38, 2'h0, 8'h00);
        end
        CMD_IDENT: begin
          put(RSP_ACK);
          put(ID_A);
          put(ID_B);
        end
        CMD_RESEND: put(8'(m_last));
        CMD_RESET: begin
          put(RSP_ACK);
          m_scan = 0;
        end
        CMD_LED, CMD_SCANSET, CMD_RATE: begin
          put(RSP_ACK);
          m_prev = m_scan;
          m_scan = 0;
          m_opt = (b == CMD_LED) ? 1 : (b == CMD_SCANSET) ? 2 : 4;
          if (b == CMD_SCANSET) begin
            m_flush++;
            ev(6'h30, 2'h0, 8'h00);
          end
        end
        8'hf6, 8'hf7, 8'hf8, 8'hf9, 8'hfa, 8'hfb, 8'hfc, 8'hfd: begin
          put(RSP_ACK);
          m_flush++;
          if (b == CMD_DEFAULT) ev(6'h38, 2'h0, 8'h00);
          else if (b <= CMD_ALLK_HI) ev(6'h24, 2'(b - CMD_ALLK_LO), 8'h00);
          else ev(6'h20, 2'h0, 8'h00);
          if (b > CMD_ALLK_HI) begin
            m_opt = 3;
            m_kt = 2'(b - CMD_KEYT_LO);
          end
        end
        default: put(RSP_RESEND);
      endcase
    end
  endtask : mdl

  task settle;
    int k;
    for (k = 0; k < 3000 && host_u.got.size() < exp_q.size(); k++) @(posedge sys_clk_i);
    repeat (40) @(negedge sys_clk_i);
    while (exp_q.size() > 0)
      chk("reply", exp_q.pop_front(), host_u.got.size() ? host_u.got.pop_front() : 8'hxx);
    chk("extra replies", 8'h00, 8'(host_u.got.size()));
    host_u.got.delete();
    while (xev_q.size() > 0)
      chk("event", xev_q.pop_front(), ev_q.size() ? ev_q.pop_front() : 16'hxxxx);
    chk("extra events", 16'h0000, 16'(ev_q.size()));
    ev_q.delete();
    chk("scan enable", 8'(m_scan), 8'(scan_en));
    chk("scan set", 8'(m_set), 8'(scan_set));
    chk("indicators", 8'(m_leds), 8'(leds));
    chk("flush count", 8'(m_flush), 8'(n_flush));
  endtask : settle

  task cmd(input logic [7:0] b);
    @(negedge sys_clk_i);
    stall = 2'($urandom);
    mdl(b);
    host_u.send(b);
    settle();
  endtask : cmd

  task self_test(input logic fail, input int lo, input int hi);
    int t;
    st_fail = fail;
    run_len = 0;
    for (t = 0; t < 400 && st_run !== 1'b1; t++) @(negedge sys_clk_i);
    chk("lead-in in range", 8'h01, 8'(t >= lo && t <= hi));
    chk("test indicators", 8'h07, 8'(leds));
    host_u.send(CMD_ECHO);
    for (t = 0; t < 400 && st_run !== 1'b0; t++) @(negedge sys_clk_i);
    chk("test length in range", 8'h01, 8'(run_len >= BAT_C && run_len <= BAT_C * 5 / 3));
    put(fail ? RSP_FAIL : RSP_PASS);
    m_scan = !fail;
    m_set = 2;
    m_leds = 0;
    st_fail = 1'b0;
    settle();
  endtask : self_test

  task print_verdict;
    $display("Checks %0d, errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : print_verdict

  initial begin
    #500000;
    n_errors++;
    print_verdict();
  end

  initial begin
    void'($urandom(32'hb2bf1117));
    repeat (10) @(negedge sys_clk_i);
    srst_i = 1'b0;
    self_test(1'b0, POR_C - 1, POR_C * 40 / 3);
    cmd(CMD_ECHO);
    cmd(CMD_DFLT_DIS);
    cmd(CMD_ECHO);
    cmd(CMD_ENABLE);
    cmd(8'hef);
    cmd(8'hf1);
    cmd(CMD_RESEND);
    cmd(CMD_IDENT);
    cmd(CMD_RESEND);
    cmd(CMD_SCANSET);
    cmd(8'h03);
    cmd(CMD_SCANSET);
    cmd(8'h00);
    repeat (4) begin
      cmd(CMD_LED);
      cmd(8'($urandom % 8));
    end
    cmd(CMD_LED);
    cmd(CMD_ENABLE);
    cmd(CMD_RATE);
    cmd(8'($urandom % 128));
    cmd(CMD_RATE);
    cmd(CMD_ECHO);
    for (int b = 'hf6; b <= 'hfa; b++) cmd(8'(b));
    cmd(CMD_KEYT_LO);
    cmd(8'h1c);
    cmd(8'h5a);
    cmd(CMD_KEYT_HI);
    cmd(8'h2a);
    cmd(CMD_ENABLE);
    repeat (3) cmd(8'($urandom % 237));
    cmd(CMD_RESET);
    line_idle = 1'b1;
    repeat (IDLE_C - 3) @(negedge sys_clk_i);
    line_idle = 1'b0;
    repeat (20) @(negedge sys_clk_i);
    chk("early self-test", 8'h00, 8'(st_run));
    line_idle = 1'b1;
    self_test(1'b0, IDLE_C, IDLE_C + 8);
    line_idle = 1'b0;
    cmd(CMD_RESET);
    line_idle = 1'b1;
    self_test(1'b1, IDLE_C, IDLE_C + 8);
    cmd(CMD_ENABLE);
    print_verdict();
  end
endmodule : kci_cmd_interp_bench
`default_nettype wire
